// ### pkg/dmd_pkg.sv
package dmd_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned RAM_BYTES = 256;
  localparam int unsigned SFR_SLOTS = 128;

  localparam logic [7:0] SFR_BASE    = 8'h80;
  localparam logic [7:0] BANK_TOP    = 8'h1F;
  localparam logic [7:0] BITRAM_BASE = 8'h20;
  localparam logic [7:0] BITRAM_TOP  = 8'h2F;
  localparam logic [3:0] BITSFR_NIB0 = 4'h0;
  localparam logic [3:0] BITSFR_NIB8 = 4'h8;
  localparam logic [1:0] BANK_RST    = 2'h0;

  typedef enum logic [1:0] {
    DMD_DIRECT,
    DMD_INDIRECT,
    DMD_BIT
  } dmd_mode_t;

  // request from the core
  typedef struct packed {
    logic       valid;
    logic       write;
    dmd_mode_t  mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_val;
  } dmd_req_t;

  // routed access, one cycle after the request
  typedef struct packed {
    logic       valid;
    logic       to_sfr;
    logic       write;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_val;
    logic       bad_bit;
  } dmd_route_t;

endpackage : dmd_pkg

// ### logic/dmd_ram.sv
module dmd_ram (
  // clock only, no reset
  input  wire logic       clk_i,
  // access port
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);

  logic [7:0] mem_r [dmd_pkg::RAM_BYTES];

  // no reset on the array: ram contents are undefined at power up
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_r[addr_i];
  end

endmodule : dmd_ram

// ### logic/dmd_decoder.sv
// Overview of operation
// - direct accesses at 0x80..0xFF go to the register space, not ram
// - indirect accesses to the upper half reach general purpose ram
// - lower 128 bytes: direct and indirect reach the same ram byte
// - 256 bytes of data ram sit behind the decoder
// - lowest 32 ram bytes form four banks of working registers
// - the 16 bytes after the banks allow byte and bit access
// - registers with low nibble 0x0 or 0x8 allow bit operations
// - other registers are byte access only, bit operations refused
module dmd_decoder (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // core request
  input  wire dmd_pkg::dmd_req_t req_i,
  input  wire logic              wreg_i,
  input  wire logic [2:0]        wreg_idx_i,
  input  wire logic [1:0]        bank_sel_i,
  input  wire logic              bank_sel_we_i,
  // register space side
  output dmd_pkg::dmd_route_t    sfr_o,
  input  wire logic [7:0]        sfr_rdata_i,
  // answer to core
  output logic                   rvalid_o,
  output logic [7:0]             rdata_o,
  output logic                   rbit_o,
  output logic                   bit_err_o,
  output logic [1:0]             bank_o
);

  function automatic logic sfr_bit_ok(input logic [7:0] a);
    return (a[3:0] == dmd_pkg::BITSFR_NIB0) ||
           (a[3:0] == dmd_pkg::BITSFR_NIB8);
  endfunction : sfr_bit_ok

  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b < dmd_pkg::SFR_BASE) begin
      return dmd_pkg::BITRAM_BASE + {4'h0, b[6:3]};
    end else begin
      return {b[7:3], 3'h0};
    end
  endfunction : bit_byte

  logic [1:0]          bank_r;
  dmd_pkg::dmd_route_t rt_nxt;
  dmd_pkg::dmd_route_t rt_r;
  logic [7:0]          ram_addr;
  logic                ram_we;
  logic [7:0]          ram_wdata;
  logic [7:0]          ram_rdata;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_r <= dmd_pkg::BANK_RST;
    end else if (bank_sel_we_i) begin
      bank_r <= bank_sel_i;
    end
  end

  always_comb begin
    rt_nxt         = '0;
    rt_nxt.valid   = req_i.valid;
    rt_nxt.write   = req_i.write;
    rt_nxt.wdata   = req_i.wdata;
    rt_nxt.bit_val = req_i.bit_val;
    rt_nxt.addr    = req_i.addr;
    if (wreg_i) begin
      rt_nxt.addr = {3'h0, bank_r, wreg_idx_i};
    end else if (req_i.mode == dmd_pkg::DMD_BIT) begin
      rt_nxt.bit_op  = 1'b1;
      rt_nxt.bit_idx = req_i.addr[2:0];
      rt_nxt.addr    = bit_byte(req_i.addr);
      rt_nxt.to_sfr  = req_i.addr[7];
    end else if (req_i.mode == dmd_pkg::DMD_DIRECT) begin
      rt_nxt.to_sfr = req_i.addr[7];
    end else begin
      rt_nxt.to_sfr = 1'b0;
    end
    rt_nxt.bad_bit = rt_nxt.bit_op && rt_nxt.to_sfr &&
                     !sfr_bit_ok(rt_nxt.addr);
  end

  // the register space gets a registered view of the access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rt_r <= '0;
    end else begin
      rt_r <= rt_nxt;
    end
  end

  // writes land one cycle after the request; a bit write merges into the
  // byte that the ram read on the request edge (read-modify-write)
  // limitation: the port is shared, so a write must not be followed at
  // once by another request; the core leaves one idle cycle
  assign ram_we    = rt_r.valid && rt_r.write && !rt_r.to_sfr;
  assign ram_addr  = ram_we ? rt_r.addr : rt_nxt.addr;
  assign ram_wdata = rt_r.bit_op ?
                     (ram_rdata & ~(8'h01 << rt_r.bit_idx)) |
                     ({7'h0, rt_r.bit_val} << rt_r.bit_idx) :
                     rt_r.wdata;

  dmd_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .addr_i  (ram_addr),
    .wdata_i (ram_wdata),
    .rdata_o (ram_rdata)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_o     <= '0;
      rvalid_o  <= 1'b0;
      rdata_o   <= 8'h00;
      rbit_o    <= 1'b0;
      bit_err_o <= 1'b0;
      bank_o    <= dmd_pkg::BANK_RST;
    end else begin
      sfr_o     <= rt_nxt.to_sfr ? rt_nxt : '0;
      rvalid_o  <= rt_r.valid && !rt_r.write;
      rdata_o   <= rt_r.to_sfr ? sfr_rdata_i : ram_rdata;
      rbit_o    <= rt_r.to_sfr ? sfr_rdata_i[rt_r.bit_idx] :
                   ram_rdata[rt_r.bit_idx];
      bit_err_o <= rt_r.valid && rt_r.bad_bit;
      bank_o    <= bank_r;
    end
  end

  // direct access into the upper half
  sequence s_direct_high;
    req_i.valid && !wreg_i && req_i.mode == dmd_pkg::DMD_DIRECT &&
    req_i.addr[7];
  endsequence : s_direct_high

  // indirect access anywhere
  sequence s_indirect;
    req_i.valid && !wreg_i && req_i.mode == dmd_pkg::DMD_INDIRECT;
  endsequence : s_indirect

  // bit access below the register space
  sequence s_bit_low;
    req_i.valid && !wreg_i && req_i.mode == dmd_pkg::DMD_BIT &&
    !req_i.addr[7];
  endsequence : s_bit_low

  // bit access into the register space
  sequence s_bit_high;
    req_i.valid && !wreg_i && req_i.mode == dmd_pkg::DMD_BIT &&
    req_i.addr[7];
  endsequence : s_bit_high

  // working register access
  sequence s_wreg_req;
    req_i.valid && wreg_i;
  endsequence : s_wreg_req

  sequence s_read_req;
    req_i.valid && !req_i.write;
  endsequence : s_read_req

  sequence s_write_req;
    req_i.valid && req_i.write;
  endsequence : s_write_req

  a_direct_sfr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_direct_high |=> sfr_o.valid && sfr_o.addr == $past(req_i.addr))
    else $error("direct high access not sent to registers");

  a_indirect_ram: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_indirect |=> !sfr_o.valid)
    else $error("indirect access reached registers");

  a_bit_ram_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_bit_low |=> !sfr_o.valid)
    else $error("low bit address reached registers");

  a_bit_sfr_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_bit_high |=> sfr_o.valid && sfr_o.bit_op)
    else $error("high bit address missed registers");

  // a bit operation may only ever reach a register with nibble 0 or 8
  a_bit_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sfr_o.valid && sfr_o.bit_op |->
    (sfr_o.addr[3:0] == dmd_pkg::BITSFR_NIB0 ||
     sfr_o.addr[3:0] == dmd_pkg::BITSFR_NIB8) && !sfr_o.bad_bit)
    else $error("bit operation on byte-only register");

  a_wreg_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wreg_req |=> rt_r.addr[4:3] == $past(bank_r) &&
    rt_r.addr[2:0] == $past(wreg_idx_i) && !rt_r.to_sfr)
    else $error("working register outside active bank");

  a_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_read_req |-> ##2 rvalid_o)
    else $error("read not answered");

  a_write_silent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_write_req |-> ##2 !rvalid_o)
    else $error("write gave a read answer");

  a_bank_track: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bank_sel_we_i |-> ##2 bank_o == $past(bank_sel_i, 2))
    else $error("bank select not followed");

endmodule : dmd_decoder

// ### tb/dmd_sfr_model.sv
module dmd_sfr_model (
  // clock
  input  wire logic                clk_i,
  // routed access from the decoder
  input  wire dmd_pkg::dmd_route_t sfr_i,
  output logic [7:0]               rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem    [128];
  logic [7:0] last_r = 8'h00;
  // idle bus shows the inverse of the last value so stale reads show up
  assign rdata_o = sfr_i.valid ? mem[sfr_i.addr[6:0]] : ~last_r;
  always @(posedge clk_i) begin
    if (sfr_i.valid) begin
      last_r <= mem[sfr_i.addr[6:0]];
      if (sfr_i.write && !sfr_i.bad_bit) begin
        if (sfr_i.bit_op) begin
          mem[sfr_i.addr[6:0]][sfr_i.bit_idx] <= sfr_i.bit_val;
        end else begin
          mem[sfr_i.addr[6:0]] <= sfr_i.wdata;
        end
      end
    end
  end
endmodule : dmd_sfr_model

// ### tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam dmd_pkg::dmd_mode_t DR = dmd_pkg::DMD_DIRECT;
  localparam dmd_pkg::dmd_mode_t IN = dmd_pkg::DMD_INDIRECT;
  localparam dmd_pkg::dmd_mode_t BT = dmd_pkg::DMD_BIT;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  dmd_pkg::dmd_req_t   req = '0;
  dmd_pkg::dmd_route_t sfr;
  logic       wreg = 1'b0, bsel_we = 1'b0, rvalid, rbit, bit_err, rb;
  logic [1:0] bsel = 2'h0, bank;
  logic [7:0] sfr_rd, rdata;
  int n_mismatch = 0, comparisons = 0;
  dmd_decoder i_dut (.clk_i(clk_i), .rst_n_i(rst_n), .req_i(req),
    .wreg_i(wreg), .wreg_idx_i(req.addr[2:0]), .bank_sel_i(bsel),
    .bank_sel_we_i(bsel_we), .sfr_o(sfr), .sfr_rdata_i(sfr_rd),
    .rvalid_o(rvalid), .rdata_o(rdata), .rbit_o(rbit),
    .bit_err_o(bit_err), .bank_o(bank));
  dmd_sfr_model i_sfr (.clk_i(clk_i), .sfr_i(sfr), .rdata_o(sfr_rd));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] g, e, input string s);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, s);
    end
  endtask : chk
  // one access, then idle cycles so bit writes get their gap
  task automatic acc(input logic w, input dmd_pkg::dmd_mode_t m,
      input logic [7:0] a, d, input logic wr, output logic [7:0] q,
      output logic sv, be);
    @(negedge clk_i);
    req = '{1'b1, w, m, a, d, d[0]};
    wreg = wr;
    @(negedge clk_i);
    sv = sfr.valid;
    req.valid = 1'b0;
    wreg = 1'b0;
    @(negedge clk_i);
    q = rdata;
    be = bit_err;
    rb = rbit;
    if (!w) chk(rvalid, 1'b1, "no answer");
    else chk(rvalid, 1'b0, "write answered");
    @(negedge clk_i);
  endtask : acc
  task automatic t_dual;
    logic [7:0] q;
    logic sv, be;
    acc(1, DR, 8'h90, 8'h5A, 0, q, sv, be); chk(sv, 1, "direct");
    acc(1, IN, 8'h90, 8'hC3, 0, q, sv, be); chk(sv, 0, "indirect");
    acc(0, DR, 8'h90, 0, 0, q, sv, be); chk(q, 8'h5A, "reg rd");
    acc(0, IN, 8'h90, 0, 0, q, sv, be); chk(q, 8'hC3, "ram rd");
    acc(1, DR, 8'h45, 8'h3C, 0, q, sv, be);
    acc(0, IN, 8'h45, 0, 0, q, sv, be); chk(q, 8'h3C, "low");
  endtask : t_dual
  task automatic t_bits;
    logic [7:0] q;
    logic sv, be;
    acc(1, DR, 8'h21, 8'h00, 0, q, sv, be);
    acc(1, BT, 8'h0B, 8'h01, 0, q, sv, be); chk(sv, 0, "bit ram");
    acc(0, DR, 8'h21, 0, 0, q, sv, be); chk(q, 8'h08, "bit ram");
    acc(1, DR, 8'h91, 8'h00, 0, q, sv, be);
    acc(0, BT, 8'h0B, 0, 0, q, sv, be); chk(rb, 1, "bit rd");
    acc(0, BT, 8'h0A, 0, 0, q, sv, be); chk(rb, 0, "bit rd0");
    acc(1, BT, 8'h92, 8'h01, 0, q, sv, be); chk(sv, 1, "bit reg");
    chk(be, 0, "bit err");
    acc(0, BT, 8'h92, 0, 0, q, sv, be); chk(rb, 1, "bit reg rd");
    acc(0, DR, 8'h90, 0, 0, q, sv, be); chk(q, 8'h5E, "bit reg");
    acc(0, DR, 8'h91, 0, 0, q, sv, be); chk(q, 8'h00, "spill");
  endtask : t_bits
  task automatic t_bank;
    logic [7:0] q;
    logic sv, be;
    chk(bank, 2'h0, "bank rst");
    @(negedge clk_i);
    bsel = 2'h2;
    bsel_we = 1'b1;
    @(negedge clk_i);
    bsel_we = 1'b0;
    @(negedge clk_i);
    chk(bank, 2'h2, "bank load");
    acc(1, DR, 8'h05, 8'h77, 1, q, sv, be);
    acc(0, IN, 8'h15, 0, 0, q, sv, be); chk(q, 8'h77, "wreg");
  endtask : t_bank
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(negedge clk_i);
    rst_n = 1'b1;
    t_dual;
    t_bits;
    t_bank;
    stop_test;
  end
  // about 90 cycles of work; a hang is cut well after that
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    stop_test;
  end
endmodule : testbench
